// ---- hdl/icw_defines.vh ----
// constants for the two-way fetch cache: offsets, fields, reset values, timing
`ifndef ICW_DEFINES_VH
`define ICW_DEFINES_VH
// register map (byte addresses on the 13-bit apb window)
`define ICW_OFF_CTRL 13'h0000
`define ICW_OFF_STAT 13'h0004
`define ICW_TAG_BASE 13'h0400
`define ICW_TAG_MASK 13'h1C00
`define ICW_DAT_BASE 13'h1000
`define ICW_DAT_MASK 13'h1000
// control register fields
`define ICW_CTRL_EN 0
`define ICW_CTRL_FLUSH 1
`define ICW_CTRL_RAM 2
`define ICW_CTRL_RST 3'h0
// tag word fields
`define ICW_TAG_HI 31
`define ICW_TAG_LO 9
`define ICW_SBV_HI 7
`define ICW_SBV_LO 4
`define ICW_TV_BIT 3
`define ICW_LRU_BIT 1
`define ICW_LK_BIT 0
// cache geometry
`define ICW_BLOCKS 128
`define ICW_SUBS 4
// fetches that still see the old control value after a control write
`define ICW_CTRL_DELAY 3
`endif

// ---- hdl/icw_way_pick.v ----
// way choice for a fetch miss in the two-way fetch cache
`timescale 1ns/10ps
module icw_way_pick (
   input wire match0_in,
   input wire match1_in,
   input wire valid0_in,
   input wire valid1_in,
   input wire lock0_in,
   input wire lock1_in,
   input wire lru_in,
   output reg fill_ok_out,
   output reg fill_way_out,
   output reg keep_tag_out,
   output wire both_locked_out
);
   assign both_locked_out = lock0_in & lock1_in;

   // a matching way only lacks the sub-block, so it is topped up even if locked
   always @* begin
      fill_ok_out = 1'b1;
      fill_way_out = 1'b0;
      keep_tag_out = 1'b0;
      if (match0_in) begin
         keep_tag_out = 1'b1;
      end else if (match1_in) begin
         fill_way_out = 1'b1;
         keep_tag_out = 1'b1;
      end else if (!valid0_in) begin
         fill_way_out = 1'b0;
      end else if (!valid1_in) begin
         fill_way_out = 1'b1;
      end else if (!lock0_in && !lock1_in) begin
         fill_way_out = lru_in;
      end else if (!lock0_in) begin
         fill_way_out = 1'b0;
      end else if (!lock1_in) begin
         fill_way_out = 1'b1;
      end else begin
         fill_ok_out = 1'b0;
      end
   end
endmodule // icw_way_pick

// ---- hdl/icw_fetch_cache.v ----
// two-way set associative fetch cache with apb control and ram mode
`timescale 1ns/10ps
`include "icw_defines.vh"

module icw_fetch_cache #(
   parameter BLOCKS = `ICW_BLOCKS
) (
   input wire clk_in,
   input wire srst_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [12:0] paddr_in,
   input wire [31:0] pwdata_in,
   output reg [31:0] prdata_out,
   output reg pready_out,
   output reg pslverr_out,
   input wire fetch_req_in,
   input wire [31:0] fetch_addr_in,
   output reg fetch_busy_out,
   output reg fetch_valid_out,
   output reg [31:0] fetch_data_out,
   output reg bus_req_out,
   output reg [31:0] bus_addr_out,
   input wire bus_ack_in,
   input wire [31:0] bus_data_in
);
   localparam ST_IDLE = 2'd0;
   localparam ST_EVAL = 2'd1;
   localparam ST_MISS = 2'd2;

   // tag store, one entry per block per way
   reg [22:0] tag0_mem [0:BLOCKS-1];
   reg [22:0] tag1_mem [0:BLOCKS-1];
   reg [3:0] sbv0_mem [0:BLOCKS-1];
   reg [3:0] sbv1_mem [0:BLOCKS-1];
   reg tv0_mem [0:BLOCKS-1];
   reg tv1_mem [0:BLOCKS-1];
   reg lk0_mem [0:BLOCKS-1];
   reg lk1_mem [0:BLOCKS-1];
   reg lru_mem [0:BLOCKS-1];
   // data store: way, index, sub-block
   reg [31:0] data_mem [0:2*BLOCKS*4-1];

   reg [2:0] ctrl_ff;
   reg [2:0] pipe1_ff;
   reg [2:0] pipe2_ff;
   reg [2:0] act_ff;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [31:0] miss_addr_ff;
   reg fill_ok_ff;
   reg fill_way_ff;
   reg keep_tag_ff;
   integer i;

   // storage layout notes:
   // - the tag keeps all of address bits 31 to 9, so bits 10 and 9 sit in both tag and index
   // - a block is valid only with its block valid flag set, whatever the sub-block flags say
   // - the lru flag is kept once per set, it reads back only through way 0 tag words
   // - the data store has no reset, so a valid flag must be set before its word is trusted
   // - lock flags are changed by software only, a fill never touches them

   // address split: word address is tag, index and sub-block
   function [9:0] data_idx;
      input way;
      input [6:0] idx;
      input [1:0] sub;
      begin
         data_idx = {way, idx, sub};
      end
   endfunction

   function hit_way;
      input [22:0] tag;
      input [22:0] atag;
      input tv;
      input [3:0] sbv;
      input [1:0] sub;
      begin
         hit_way = tv && (tag == atag) && sbv[sub];
      end
   endfunction

   // current fetch lookup
   wire [22:0] f_tag = fetch_addr_in[`ICW_TAG_HI:`ICW_TAG_LO];
   wire [6:0] f_idx = fetch_addr_in[10:4];
   wire [1:0] f_sub = fetch_addr_in[3:2];
   wire hit0 = hit_way(tag0_mem[f_idx], f_tag, tv0_mem[f_idx], sbv0_mem[f_idx], f_sub);
   wire hit1 = hit_way(tag1_mem[f_idx], f_tag, tv1_mem[f_idx], sbv1_mem[f_idx], f_sub);
   wire match0 = tv0_mem[f_idx] && (tag0_mem[f_idx] == f_tag);
   wire match1 = tv1_mem[f_idx] && (tag1_mem[f_idx] == f_tag);
   wire cache_on = act_ff[`ICW_CTRL_EN] && !act_ff[`ICW_CTRL_RAM];
   wire take = fetch_req_in && !fetch_busy_out;
   wire hit_now = take && cache_on && (hit0 || hit1);
   wire pick_ok;
   wire pick_way;
   wire pick_keep;
   wire both_lk;

   // miss fields
   wire [22:0] m_tag = miss_addr_ff[`ICW_TAG_HI:`ICW_TAG_LO];
   wire [6:0] m_idx = miss_addr_ff[10:4];
   wire [1:0] m_sub = miss_addr_ff[3:2];
   wire fill_now = (state_ff == ST_MISS) && bus_ack_in && fill_ok_ff;

   // apb decode
   wire apb_setup = psel_in && !penable_in;
   wire apb_done = psel_in && penable_in && pready_out;
   wire sel_ctrl = (paddr_in == `ICW_OFF_CTRL);
   wire sel_stat = (paddr_in == `ICW_OFF_STAT);
   wire sel_tag = ((paddr_in & `ICW_TAG_MASK) == `ICW_TAG_BASE);
   wire sel_dat = ((paddr_in & `ICW_DAT_MASK) == `ICW_DAT_BASE);
   wire ram_on = act_ff[`ICW_CTRL_RAM];
   wire dat_ok = sel_dat && ram_on;
   wire t_way = paddr_in[9];
   wire [6:0] t_idx = paddr_in[8:2];
   wire [9:0] d_ix = paddr_in[11:2];

   icw_way_pick u_pick (
      .match0_in(match0),
      .match1_in(match1),
      .valid0_in(tv0_mem[f_idx]),
      .valid1_in(tv1_mem[f_idx]),
      .lock0_in(lk0_mem[f_idx]),
      .lock1_in(lk1_mem[f_idx]),
      .lru_in(lru_mem[f_idx]),
      .fill_ok_out(pick_ok),
      .fill_way_out(pick_way),
      .keep_tag_out(pick_keep),
      .both_locked_out(both_lk)
   );

   // hazard: a control write must not change the handling of fetches already on their way,
   // so the written value walks through three stages before the fetch logic sees it.
   // the flush bit is a one-cycle request; it travels the same stages and clears the
   // block valid flags at the fourth edge, never earlier than the enable change
   // status bit 3 shows that a written value has not yet reached the last stage
   // control delay line: fetches taken in the next three edges see the old value
   always @(posedge clk_in) begin
      if (srst_in) begin
         ctrl_ff <= `ICW_CTRL_RST;
         pipe1_ff <= `ICW_CTRL_RST;
         pipe2_ff <= `ICW_CTRL_RST;
         act_ff <= `ICW_CTRL_RST;
      end else begin
         if (apb_done && pwrite_in && sel_ctrl) begin
            ctrl_ff <= pwdata_in[2:0];
         end else begin
            ctrl_ff[`ICW_CTRL_FLUSH] <= 1'b0; // flush request is a single pulse
         end
         pipe1_ff <= ctrl_ff;
         pipe2_ff <= pipe1_ff;
         act_ff <= pipe2_ff;
      end
   end

   // one miss at a time: a request seen while busy is left for the fetch side to hold.
   // with the cache on, both ways locked costs one evaluation cycle, even when a locked way matches the tag,
   // so the bus request then rises one edge later than for an ordinary miss
   // the machine leaves the miss state only on the edge that samples the bus answer
   // fetch state machine next state
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (take && !hit_now) begin
               if (cache_on && both_lk) begin
                  nxt_state = ST_EVAL;
               end else begin
                  nxt_state = ST_MISS;
               end
            end
         end
         ST_EVAL: begin
            nxt_state = ST_MISS;
         end
         ST_MISS: begin
            if (bus_ack_in) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // fetch answers, miss bookkeeping and bus request
   always @(posedge clk_in) begin
      if (srst_in) begin
         state_ff <= ST_IDLE;
         fetch_busy_out <= 1'b0;
         fetch_valid_out <= 1'b0;
         fetch_data_out <= 32'h00000000;
         bus_req_out <= 1'b0;
         bus_addr_out <= 32'h00000000;
         miss_addr_ff <= 32'h00000000;
         fill_ok_ff <= 1'b0;
         fill_way_ff <= 1'b0;
         keep_tag_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         fetch_valid_out <= 1'b0;
         fetch_busy_out <= (nxt_state != ST_IDLE);
         if (state_ff == ST_IDLE && take) begin
            miss_addr_ff <= fetch_addr_in;
            fill_ok_ff <= cache_on && pick_ok;
            fill_way_ff <= pick_way;
            keep_tag_ff <= pick_keep;
            if (hit_now) begin
               fetch_valid_out <= 1'b1;
               fetch_data_out <= data_mem[data_idx(hit1, f_idx, f_sub)];
            end
         end
         // bus request starts after the lookup, or after the extra evaluation cycle
         if (nxt_state == ST_MISS && state_ff != ST_MISS) begin
            bus_req_out <= 1'b1;
            bus_addr_out <= (state_ff == ST_IDLE) ? {fetch_addr_in[31:2], 2'b00}
                                                  : {miss_addr_ff[31:2], 2'b00};
         end
         if (state_ff == ST_MISS && bus_ack_in) begin
            bus_req_out <= 1'b0;
            fetch_valid_out <= 1'b1;
            fetch_data_out <= bus_data_in;
         end
      end
   end

   // a bus fill and a software write cannot meet in a useful way: software writes
   // are accepted only in ram mode, and no fill is armed while ram mode is active.
   // should both happen in one cycle the fill is kept and the software word is lost
   // data store: fill from the bus or software access in ram mode
   always @(posedge clk_in) begin
      if (fill_now) begin
         data_mem[data_idx(fill_way_ff, m_idx, m_sub)] <= bus_data_in;
      end else if (apb_done && pwrite_in && dat_ok) begin
         data_mem[d_ix] <= pwdata_in;
      end
   end

   // priority: reset, then flush, then the fill, then software tag writes.
   // a flush in the same cycle as a fill wins, so the filled block stays invalid
   // and the next fetch of that word goes to the bus again; the word in the data
   // store is then simply refetched and rewritten
   // a replacing fill drops the other sub-block flags of the old tag
   // tag store: reset, flush, fill, lru on hit, software writes
   always @(posedge clk_in) begin
      if (srst_in) begin
         for (i = 0; i < BLOCKS; i = i + 1) begin
            tv0_mem[i] <= 1'b0;
            tv1_mem[i] <= 1'b0;
            sbv0_mem[i] <= 4'h0;
            sbv1_mem[i] <= 4'h0;
            lk0_mem[i] <= 1'b0;
            lk1_mem[i] <= 1'b0;
            lru_mem[i] <= 1'b0;
         end
      end else if (act_ff[`ICW_CTRL_FLUSH]) begin
         for (i = 0; i < BLOCKS; i = i + 1) begin
            tv0_mem[i] <= 1'b0;
            tv1_mem[i] <= 1'b0;
         end
      end else begin
         if (hit_now) begin
            lru_mem[f_idx] <= hit0;
         end
         if (fill_now) begin
            lru_mem[m_idx] <= !fill_way_ff;
            if (!fill_way_ff) begin
               tag0_mem[m_idx] <= m_tag;
               tv0_mem[m_idx] <= 1'b1;
               sbv0_mem[m_idx] <= (keep_tag_ff ? sbv0_mem[m_idx] : 4'h0) | (4'h1 << m_sub);
            end else begin
               tag1_mem[m_idx] <= m_tag;
               tv1_mem[m_idx] <= 1'b1;
               sbv1_mem[m_idx] <= (keep_tag_ff ? sbv1_mem[m_idx] : 4'h0) | (4'h1 << m_sub);
            end
         end else if (apb_done && pwrite_in && sel_tag) begin
            // software may preload, lock or invalidate entries
            if (!t_way) begin
               tag0_mem[t_idx] <= pwdata_in[`ICW_TAG_HI:`ICW_TAG_LO];
               sbv0_mem[t_idx] <= pwdata_in[`ICW_SBV_HI:`ICW_SBV_LO];
               tv0_mem[t_idx] <= pwdata_in[`ICW_TV_BIT];
               lk0_mem[t_idx] <= pwdata_in[`ICW_LK_BIT];
               lru_mem[t_idx] <= pwdata_in[`ICW_LRU_BIT];
            end else begin
               tag1_mem[t_idx] <= pwdata_in[`ICW_TAG_HI:`ICW_TAG_LO];
               sbv1_mem[t_idx] <= pwdata_in[`ICW_SBV_HI:`ICW_SBV_LO];
               tv1_mem[t_idx] <= pwdata_in[`ICW_TV_BIT];
               lk1_mem[t_idx] <= pwdata_in[`ICW_LK_BIT];
            end
         end
      end
   end

   // zero wait states: pready rises in the access cycle and falls the next one.
   // read data is captured at the setup edge, so a fill landing in the access cycle
   // is not seen by that read; software sees it on its next read
   // refused accesses answer with the error flag and read data of zero
   // apb slave: one access cycle, read data captured in the setup cycle
   always @(posedge clk_in) begin
      if (srst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h00000000;
      end else if (apb_setup) begin
         pready_out <= 1'b1;
         pslverr_out <= !(sel_ctrl || sel_stat || sel_tag || dat_ok);
         prdata_out <= 32'h00000000;
         if (!pwrite_in) begin
            if (sel_ctrl) begin
               prdata_out <= {29'h00000000, ctrl_ff};
            end else if (sel_stat) begin
               prdata_out <= {28'h0000000, (ctrl_ff != act_ff), fetch_busy_out, act_ff[`ICW_CTRL_RAM],
                              act_ff[`ICW_CTRL_EN]};
            end else if (sel_tag && !t_way) begin
               prdata_out <= {tag0_mem[t_idx], 1'b0, sbv0_mem[t_idx], tv0_mem[t_idx], 1'b0,
                              lru_mem[t_idx], lk0_mem[t_idx]};
            end else if (sel_tag) begin
               prdata_out <= {tag1_mem[t_idx], 1'b0, sbv1_mem[t_idx], tv1_mem[t_idx], 2'b00,
                              lk1_mem[t_idx]};
            end else if (dat_ok) begin
               prdata_out <= data_mem[d_ix];
            end
         end
      end else begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end
   end
endmodule // icw_fetch_cache

// ---- bench/icw_fetch_cache_props.sv ----
// port assertions for the two-way fetch cache
`timescale 1ns/10ps
module icw_fetch_cache_props #(
   parameter BLOCKS = 128
) (
   input wire clk_in,
   input wire srst_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [12:0] paddr_in,
   input wire [31:0] pwdata_in,
   input wire [31:0] prdata_out,
   input wire pready_out,
   input wire pslverr_out,
   input wire fetch_req_in,
   input wire [31:0] fetch_addr_in,
   input wire fetch_busy_out,
   input wire fetch_valid_out,
   input wire [31:0] fetch_data_out,
   input wire bus_req_out,
   input wire [31:0] bus_addr_out,
   input wire bus_ack_in,
   input wire [31:0] bus_data_in
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // a bus answer and the fetch answer that must follow it
   sequence s_ack;
      bus_req_out && bus_ack_in;
   endsequence
   sequence s_fill;
      !bus_req_out && !fetch_busy_out && fetch_valid_out;
   endsequence
   a_apb_answer: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
      else $error("apb answer not a single cycle after setup");
   a_err_zero: assert property (pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
      else $error("refused read returned data");
   a_bus_hold: assert property (bus_req_out && !bus_ack_in |=> bus_req_out && $stable(bus_addr_out))
      else $error("bus request dropped or moved before ack");
   a_fill_answer: assert property (s_ack |=> s_fill)
      else $error("bus answer not passed to fetch side");
   a_fill_data: assert property (s_ack |=> fetch_data_out == $past(bus_data_in))
      else $error("fetch data differs from bus word");
   a_word_access: assert property (bus_req_out |-> bus_addr_out[1:0] == 2'h0 && fetch_busy_out)
      else $error("bus access not one aligned word of a miss");
   a_hit_answer: assert property (fetch_req_in && !fetch_busy_out ##1 !fetch_busy_out |-> fetch_valid_out)
      else $error("hit not answered in next cycle");
   a_eval_cycle: assert property (fetch_busy_out && !bus_req_out |=> bus_req_out)
      else $error("miss evaluation longer than one cycle");
   a_valid_cause: assert property (fetch_valid_out |->
      ($past(fetch_req_in) && !$past(fetch_busy_out)) || ($past(bus_req_out) && $past(bus_ack_in)))
      else $error("fetch answer without a cause");
   a_busy_end: assert property ($fell(fetch_busy_out) && !$past(srst_in) |-> fetch_valid_out)
      else $error("miss ended without an answer");
endmodule // icw_fetch_cache_props

bind icw_fetch_cache icw_fetch_cache_props #(.BLOCKS(BLOCKS)) u_icw_fetch_cache_props (.clk_in, .srst_in,
   .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
   .fetch_req_in, .fetch_addr_in, .fetch_busy_out, .fetch_valid_out, .fetch_data_out, .bus_req_out,
   .bus_addr_out, .bus_ack_in, .bus_data_in);

// ---- bench/icw_bus_model.sv ----
// far-side bus controller model answering single word reads
`timescale 1ns/10ps
module icw_bus_model (
   input wire clk_in,
   input wire srst_in,
   input wire bus_req_in,
   input wire [31:0] bus_addr_in,
   output logic bus_ack_out,
   output logic [31:0] bus_data_out
);
   logic [1:0] wait_ff;
   logic slow_ff;
   // answers alternate between prompt and two idle cycles
   always @(posedge clk_in) begin
      if (srst_in) begin
         bus_ack_out <= 1'b0;
         bus_data_out <= 32'h0;
         wait_ff <= 2'h0;
         slow_ff <= 1'b0;
      end else if (bus_req_in && !bus_ack_out && wait_ff == {slow_ff, 1'b0}) begin
         bus_ack_out <= 1'b1; // one word per access
         bus_data_out <= bus_addr_in ^ 32'hA5C30000;
         wait_ff <= 2'h0;
         slow_ff <= !slow_ff;
      end else begin
         bus_ack_out <= 1'b0;
         bus_data_out <= ~bus_data_out; // no stale word between answers
         if (bus_req_in && !bus_ack_out) wait_ff <= wait_ff + 2'h1;
      end
   end
endmodule // icw_bus_model

// ---- bench/icw_fetch_cache_tb.sv ----
// self-checking testbench for the two-way fetch cache
`timescale 1ns/10ps
module icw_fetch_cache_tb;
   localparam logic [31:0] A = 32'h00012340, B = 32'h00012B40, C = 32'h00013340;
   localparam logic [31:0] TM = 32'hFFFFFE00, KEY = 32'hA5C30000, HIT = 32'hFFFFFFFF;
   localparam logic [12:0] T1 = 13'h04D0, T2 = 13'h06D0;
   logic clk_in, srst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, fetch_req_in = 1'b0;
   logic [12:0] paddr_in = 13'h0;
   logic [31:0] pwdata_in = 32'h0, fetch_addr_in = 32'h0, rd;
   wire [31:0] prdata_out, fetch_data_out, bus_addr_out, bus_data_in;
   wire pready_out, pslverr_out, fetch_busy_out, fetch_valid_out, bus_req_out, bus_ack_in;
   logic er;
   int err_count = 0, n_tests = 0, cyc = 0, lat;
   icw_fetch_cache u_icw_fetch_cache (.clk_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .fetch_req_in, .fetch_addr_in, .fetch_busy_out,
      .fetch_valid_out, .fetch_data_out, .bus_req_out, .bus_addr_out, .bus_ack_in, .bus_data_in);
   icw_bus_model u_icw_bus_model (.clk_in, .srst_in, .bus_req_in(bus_req_out), .bus_addr_in(bus_addr_out),
      .bus_ack_out(bus_ack_in), .bus_data_out(bus_data_in));
   // 40 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   task test_done;
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task apb(input logic wr, input logic [12:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 50);
      if (pready_out !== 1'b1) chk(32'h0, 32'h1);
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   // one fetch; checks the word and the cycle at which the bus request showed
   task fetch(input logic [31:0] a, input logic [31:0] lat_exp);
      int n;
      @(posedge clk_in);
      fetch_req_in <= 1'b1;
      fetch_addr_in <= a;
      @(posedge clk_in);
      fetch_req_in <= 1'b0;
      lat = -1;
      for (n = 0; n < 200; n++) begin
         @(posedge clk_in);
         if (bus_req_out === 1'b1 && lat < 0) lat = n;
         if (fetch_valid_out === 1'b1) break;
      end
      chk(fetch_data_out, a ^ KEY);
      chk(32'(lat), lat_exp);
   endtask
   // hang guard
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         test_done;
      end
   end
   initial begin
      repeat (5) @(posedge clk_in);
      srst_in <= 1'b0;
      apb(1'b0, 13'h0000, 32'h0); chk(rd, 32'h0);
      apb(1'b0, 13'h0008, 32'h0); chk({31'h0, er}, 32'h1);
      apb(1'b0, 13'h1010, 32'h0); chk({31'h0, er}, 32'h1);
      apb(1'b0, T1, 32'h0); chk(rd, 32'h0);
      apb(1'b1, 13'h0000, 32'h1);
      repeat (4) @(posedge clk_in);
      fetch(A, 32'h0);
      fetch(A, HIT);
      apb(1'b0, T1, 32'h0); chk(rd, A & TM | 32'h1A);
      fetch(A + 4, 32'h0);
      fetch(B, 32'h0);
      fetch(B, HIT);
      apb(1'b0, T2, 32'h0); chk(rd, B & TM | 32'h18);
      apb(1'b0, T1, 32'h0); chk(rd, A & TM | 32'h38);
      fetch(A + 4, HIT);
      apb(1'b0, T1, 32'h0); chk(rd, A & TM | 32'h3A);
      // both ways locked: no replacement, one evaluation cycle
      apb(1'b1, T1, A & TM | 32'h3B);
      apb(1'b1, T2, B & TM | 32'h19);
      fetch(C, 32'h1);
      fetch(C, 32'h1);
      apb(1'b0, T2, 32'h0); chk(rd, B & TM | 32'h19);
      fetch(A + 8, 32'h1);
      apb(1'b0, T1, 32'h0); chk(rd, A & TM | 32'h7B);
      apb(1'b1, T1, A & TM | 32'h7A);
      apb(1'b1, T2, B & TM | 32'h18);
      // disable: the next fetch still sees the old control value
      apb(1'b1, 13'h0000, 32'h0);
      fetch(A, HIT);
      repeat (4) @(posedge clk_in);
      fetch(A, 32'h0);
      apb(1'b1, 13'h0000, 32'h3);
      repeat (4) @(posedge clk_in);
      apb(1'b0, T1, 32'h0); chk(rd & 32'h8, 32'h0);
      fetch(A, 32'h0);
      fetch(A, HIT);
      // ram mode: direct access to the data store
      apb(1'b1, 13'h0000, 32'h4);
      repeat (4) @(posedge clk_in);
      apb(1'b0, 13'h0000, 32'h0); chk(rd, 32'h4);
      apb(1'b0, 13'h0004, 32'h0); chk(rd, 32'h2);
      apb(1'b0, 13'h1348, 32'h0); chk(rd, (A + 8) ^ KEY);
      apb(1'b1, 13'h1010, 32'hC0DE5A01); chk({31'h0, er}, 32'h0);
      apb(1'b0, 13'h1010, 32'h0); chk(rd, 32'hC0DE5A01);
      test_done;
   end
endmodule // icw_fetch_cache_tb
